// ===== hdl/srx_consts.svh
`ifndef SRX_CONSTS_SVH
`define SRX_CONSTS_SVH

// Instruction word fields
`define SRX_INSTR_W 24
`define SRX_F_OPC 23:16
`define SRX_F_FADDR 12:0
`define SRX_F_FDIR 13
`define SRX_F_WS 3:0
`define SRX_F_WSMODE 6:4
`define SRX_F_WD 10:7
`define SRX_F_WB 14:11
`define SRX_F_REPEAT_COUNT_LITERAL 13:0
`define SRX_F_RETURN_VALUE_LITERAL 13:4
`define SRX_F_WN 3:0
`define SRX_F_SHIFT_COUNT_LITERAL 4:0
`define SRX_F_REL 15:0
`define SRX_F_RAMIDX 6:1

// Opcodes
`define SRX_OP_CALLW 8'h01
`define SRX_OP_RELATIVE_CALL_OP 8'h07
`define SRX_OP_REPL 8'h09
`define SRX_OP_REPW 8'h0A
`define SRX_OP_LITERAL_RETURN_OP 8'h0B
`define SRX_OP_RETURN 8'h0C
`define SRX_OP_INTERRUPT_RETURN_OP 8'h0D
`define SRX_OP_RESET 8'hFE
`define SRX_OP_ROTATE_RIGHT_PLAIN_F 8'hD0
`define SRX_OP_ROTATE_RIGHT_PLAIN_W 8'hD1
`define SRX_OP_RRC_F 8'hD2
`define SRX_OP_RRC_W 8'hD3
`define SRX_OP_ROTATE_LEFT_PLAIN_F 8'hD4
`define SRX_OP_ROTATE_LEFT_PLAIN_W 8'hD5
`define SRX_OP_RLC_F 8'hD6
`define SRX_OP_RLC_W 8'hD7
`define SRX_OP_SL_F 8'hD8
`define SRX_OP_SL_W 8'hD9
`define SRX_OP_SLM_W 8'hDC
`define SRX_OP_SLM_L 8'hDD
`define SRX_OP_FILL_F 8'hEE
`define SRX_OP_FILL_W 8'hEF
`define SRX_OP_SE 8'hFB
`define SRX_OP_TW0 8'h02
`define SRX_OP_TW1 8'h03
`define SRX_OP_TW2 8'h08

// Source addressing modes
`define SRX_AM_DIR 3'h0
`define SRX_AM_IND 3'h1
`define SRX_AM_POSTINC 3'h2
`define SRX_AM_POSTDEC 3'h3
`define SRX_AM_PREINC 3'h4
`define SRX_AM_PREDEC 3'h5
`define SRX_AM_OFFS 3'h6

// Sizes and constants
`define SRX_NREGS 16
`define SRX_RAM_WORDS 64
`define SRX_STK_DEPTH 8
`define SRX_WORD_STEP 16'h0002
`define SRX_ALL_ONES 16'hFFFF
`define SRX_CALL_STALL 2'h1
`define SRX_RET_STALL 2'h2
`define SRX_RET_STALL_FAST 2'h1

// Register port map
`define SRX_A_DEFAULT_WORKING_REG_HI 8'h0F
`define SRX_A_STATUS 8'h10
`define SRX_A_CTRL 8'h11
`define SRX_A_PC 8'h12
`define SRX_A_REPCNT 8'h13
`define SRX_A_RAM_LO 8'h40
`define SRX_A_RAM_HI 8'h7F

`endif

// ===== hdl/srx_exec_unit.sv
`timescale 1ns/10ps
`include "srx_consts.svh"

// Overview of operation
// (RQ1) Each 24-bit word carries an 8-bit opcode above its operand fields.
// (RQ2) Three opcodes take two words; the second word is consumed and skipped.
// (RQ3) File forms write back to the file register or to working register zero.
// (RQ4) Three-operand forms read base and source registers, write the destination register.
// (RQ5) Register fields select one of sixteen working registers.
// (RQ6) Source supports direct, indirect, post/pre inc/dec and register-offset indirect.
// (RQ7) Relative and computed calls take one word, two cycles, no flag change.
// (RQ8) Repeat runs the next instruction count plus one times; repeat itself one cycle.
// (RQ9) Software reset pulses a full reset, one cycle, flags untouched.
// (RQ10) The three returns take three cycles, two when fast, flags untouched.
// (RQ11) Literal return loads a 10-bit literal into the chosen register.
// (RQ12) Rotate left via carry, one cycle, updates C, N, Z.
// (RQ13) Plain rotate left wraps high bit to low, updates only N, Z.
// (RQ14) Rotate right via carry, one cycle, updates C, N, Z.
// (RQ15) Plain rotate right wraps low bit to high, updates only N, Z.
// (RQ16) Sign extend writes extended source to destination, updates C, N, Z.
// (RQ17) Fill writes all ones to file, default or source location, flags untouched.
// (RQ18) Single left shift, one cycle, updates C, N, OV, Z.
// (RQ19) Multi-bit left shift by register or 5-bit literal updates only N, Z.
// (RQ20) Through-carry rotates move out bit to carry, old carry into vacated bit.
module srx_exec_unit
  import srx_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Instruction stream
  input wire logic i_instr_valid,
  input wire logic [`SRX_INSTR_W-1:0] i_instr,
  output logic o_instr_ready,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // Core status
  output logic [15:0] o_pc,
  output logic [3:0] o_flags,
  output logic o_sw_reset
);

  srx_state_t s_reg;
  srx_state_t s_next;
  srx_instr_t in_cur;

  function automatic logic is_two_word(input logic [7:0] opc);
    is_two_word = (opc == `SRX_OP_TW0) || (opc == `SRX_OP_TW1) ||
                  (opc == `SRX_OP_TW2);
  endfunction

  function automatic logic is_file_form(input logic [7:0] opc);
    is_file_form = (opc == `SRX_OP_ROTATE_RIGHT_PLAIN_F) || (opc == `SRX_OP_RRC_F) ||
                   (opc == `SRX_OP_ROTATE_LEFT_PLAIN_F) || (opc == `SRX_OP_RLC_F) ||
                   (opc == `SRX_OP_SL_F) || (opc == `SRX_OP_FILL_F);
  endfunction

  // Operand decode helpers
  // Source-mode opcodes whose pointer may step
  function automatic logic uses_src_mode(input logic [7:0] opc);
    uses_src_mode = (opc == `SRX_OP_ROTATE_RIGHT_PLAIN_W) || (opc == `SRX_OP_RRC_W) ||
                    (opc == `SRX_OP_ROTATE_LEFT_PLAIN_W) || (opc == `SRX_OP_RLC_W) ||
                    (opc == `SRX_OP_SL_W) || (opc == `SRX_OP_FILL_W) ||
                    (opc == `SRX_OP_SE);
  endfunction

  // Register port address decode
  function automatic logic port_is_default_working_reg(input logic [7:0] a);
    port_is_default_working_reg = (a <= `SRX_A_DEFAULT_WORKING_REG_HI);
  endfunction

  function automatic logic port_is_ram(input logic [7:0] a);
    port_is_ram = (a >= `SRX_A_RAM_LO) && (a <= `SRX_A_RAM_HI);
  endfunction

  // Source effective address
  function automatic logic [15:0] src_addr(input logic [2:0] md,
                                           input logic [15:0] base,
                                           input logic [15:0] offs);
    case (md)
      `SRX_AM_PREINC: src_addr = base + `SRX_WORD_STEP; // [RQ6]
      `SRX_AM_PREDEC: src_addr = base - `SRX_WORD_STEP; // [RQ6]
      `SRX_AM_OFFS: src_addr = base + offs; // [RQ6]
      default: src_addr = base;
    endcase
  endfunction

  // Pointer after a post or pre step
  function automatic logic [15:0] ptr_update(input logic [2:0] md,
                                             input logic [15:0] base);
    case (md)
      `SRX_AM_POSTINC, `SRX_AM_PREINC: ptr_update = base + `SRX_WORD_STEP; // [RQ6]
      `SRX_AM_POSTDEC, `SRX_AM_PREDEC: ptr_update = base - `SRX_WORD_STEP; // [RQ6]
      default: ptr_update = base;
    endcase
  endfunction

  // N and Z; sign extend looks at the low byte
  function automatic logic [1:0] nz_of(input logic [7:0] opc, input logic [15:0] res);
    if (opc == `SRX_OP_SE) begin
      nz_of = {res[7], res[7:0] == 8'h00};
    end else begin
      nz_of = {res[15], res == 16'h0000};
    end
  endfunction

  // Register port read mux
  function automatic logic [15:0] port_read(input srx_state_t st, input logic [7:0] a);
    port_read = 16'h0000;
    if (port_is_default_working_reg(a)) begin
      port_read = st.w[a[3:0]];
    end else if (a == `SRX_A_STATUS) begin
      port_read = {12'h000, st.fl};
    end else if (a == `SRX_A_CTRL) begin
      port_read = {15'h0000, st.fast_ret};
    end else if (a == `SRX_A_PC) begin
      port_read = st.pc;
    end else if (a == `SRX_A_REPCNT) begin
      port_read = st.rep_cnt;
    end else if (port_is_ram(a)) begin
      port_read = st.ram[a[5:0]];
    end
  endfunction

  // Register port write
  function automatic srx_state_t port_write(input srx_state_t st, input logic [7:0] a,
                                            input logic [15:0] d);
    srx_state_t r;
    r = st;
    if (port_is_default_working_reg(a)) begin
      r.w[a[3:0]] = d;
    end else if (a == `SRX_A_STATUS) begin
      r.fl = d[3:0];
    end else if (a == `SRX_A_CTRL) begin
      r.fast_ret = d[0];
    end else if (port_is_ram(a)) begin
      r.ram[a[5:0]] = d;
    end
    port_write = r;
  endfunction

  // Executes one instruction word against a state copy
  function automatic srx_state_t exec_op(input srx_state_t st,
                                         input logic [`SRX_INSTR_W-1:0] ins,
                                         input logic adv);
    srx_state_t r;
    logic [7:0] opc;
    logic ffm;
    logic [3:0] ws;
    logic [3:0] wd;
    logic [3:0] wb;
    logic [2:0] md;
    logic [5:0] fidx;
    logic [15:0] base;
    logic [15:0] ea;
    logic [15:0] src;
    logic [15:0] res;
    logic [16:0] wide;
    logic [4:0] cnt;
    logic wr_dst;
    logic nz_upd;
    logic [1:0] ret_st;
    r = st;
    opc = ins[`SRX_F_OPC]; // [RQ1]
    ffm = is_file_form(opc);
    ws = ins[`SRX_F_WS]; // [RQ5]
    wd = ins[`SRX_F_WD];
    wb = ins[`SRX_F_WB];
    md = ins[`SRX_F_WSMODE];
    fidx = ins[`SRX_F_RAMIDX];
    base = st.w[ws];
    res = '0;
    wide = '0;
    cnt = '0;
    wr_dst = 1'b0;
    nz_upd = 1'b0;
    ret_st = st.fast_ret ? `SRX_RET_STALL_FAST : `SRX_RET_STALL;
    if (adv) begin
      r.pc = st.pc + 16'h0001;
    end
    // Effective address of the source operand
    ea = src_addr(md, base, st.w[wb]); // [RQ6]
    if (ffm) begin
      src = st.ram[fidx];
    end else if (md == `SRX_AM_DIR) begin
      src = base;
    end else begin
      src = st.ram[ea[`SRX_F_RAMIDX]]; // [RQ6]
    end
    // Pointer updates
    if (uses_src_mode(opc)) begin
      r.w[ws] = ptr_update(md, base); // [RQ6]
    end
    case (opc)
      `SRX_OP_RELATIVE_CALL_OP, `SRX_OP_CALLW: begin
        r.stk[st.sp] = st.pc + 16'h0001;
        r.sp = st.sp + 3'h1;
        r.pc = (opc == `SRX_OP_RELATIVE_CALL_OP) ? st.pc + 16'h0001 + ins[`SRX_F_REL] :
               st.w[ins[`SRX_F_WN]];
        r.stall = `SRX_CALL_STALL; // [RQ7]
        r.fsm = S_STALL; // [RQ7]
      end
      `SRX_OP_REPL, `SRX_OP_REPW: begin
        r.rep_cnt = (opc == `SRX_OP_REPL) ? {2'h0, ins[`SRX_F_REPEAT_COUNT_LITERAL]} :
                    st.w[ins[`SRX_F_WN]]; // [RQ8]
        r.rep_pend = 1'b1; // [RQ8]
      end
      `SRX_OP_RESET: r.rst_pend = 1'b1; // [RQ9]
      `SRX_OP_INTERRUPT_RETURN_OP, `SRX_OP_RETURN, `SRX_OP_LITERAL_RETURN_OP: begin
        r.sp = st.sp - 3'h1;
        r.pc = st.stk[st.sp - 3'h1];
        r.stall = ret_st; // [RQ10]
        r.fsm = S_STALL; // [RQ10]
        if (opc == `SRX_OP_LITERAL_RETURN_OP) begin
          r.w[ins[`SRX_F_WN]] = {6'h00, ins[`SRX_F_RETURN_VALUE_LITERAL]}; // [RQ11]
        end
      end
      `SRX_OP_RLC_F, `SRX_OP_RLC_W: begin
        res = {src[14:0], st.fl.c}; // [RQ12] [RQ20]
        r.fl.c = src[15]; // [RQ12] [RQ20]
        wr_dst = 1'b1;
        nz_upd = 1'b1;
      end
      `SRX_OP_ROTATE_LEFT_PLAIN_F, `SRX_OP_ROTATE_LEFT_PLAIN_W: begin
        res = {src[14:0], src[15]}; // [RQ13]
        wr_dst = 1'b1;
        nz_upd = 1'b1;
      end
      `SRX_OP_RRC_F, `SRX_OP_RRC_W: begin
        res = {st.fl.c, src[15:1]}; // [RQ14] [RQ20]
        r.fl.c = src[0]; // [RQ14] [RQ20]
        wr_dst = 1'b1;
        nz_upd = 1'b1;
      end
      `SRX_OP_ROTATE_RIGHT_PLAIN_F, `SRX_OP_ROTATE_RIGHT_PLAIN_W: begin
        res = {src[0], src[15:1]}; // [RQ15]
        wr_dst = 1'b1;
        nz_upd = 1'b1;
      end
      `SRX_OP_SE: begin
        res = {{8{src[7]}}, src[7:0]}; // [RQ16]
        r.w[wd] = res; // [RQ16]
        r.fl.c = ~src[7]; // [RQ16]
        nz_upd = 1'b1;
      end
      `SRX_OP_FILL_F: begin
        res = `SRX_ALL_ONES; // [RQ17]
        wr_dst = 1'b1;
      end
      `SRX_OP_FILL_W: begin
        if (md == `SRX_AM_DIR) begin
          r.w[ws] = `SRX_ALL_ONES; // [RQ17]
        end else begin
          r.ram[ea[`SRX_F_RAMIDX]] = `SRX_ALL_ONES; // [RQ17]
        end
      end
      `SRX_OP_SL_F, `SRX_OP_SL_W: begin
        res = {src[14:0], 1'b0}; // [RQ18]
        r.fl.c = src[15]; // [RQ18]
        r.fl.ov = src[15] ^ src[14]; // [RQ18]
        wr_dst = 1'b1;
        nz_upd = 1'b1;
      end
      `SRX_OP_SLM_W, `SRX_OP_SLM_L: begin
        cnt = (opc == `SRX_OP_SLM_L) ? ins[`SRX_F_SHIFT_COUNT_LITERAL] : st.w[ins[`SRX_F_WS]][4:0];
        wide = {1'b0, st.w[wb]}; // [RQ4]
        res = (cnt[4]) ? 16'h0000 : (wide[15:0] << cnt[3:0]); // [RQ19]
        r.w[wd] = res; // [RQ19] [RQ4]
        nz_upd = 1'b1;
      end
      default: begin
        if (is_two_word(opc)) begin
          r.fsm = S_EXT; // [RQ2]
        end
      end
    endcase
    if (wr_dst) begin
      if (ffm) begin
        if (ins[`SRX_F_FDIR]) begin
          r.ram[fidx] = res; // [RQ3]
        end else begin
          r.w[0] = res; // [RQ3]
        end
      end else begin
        r.w[wd] = res; // [RQ4]
      end
    end
    if (nz_upd) begin
      {r.fl.n, r.fl.z} = nz_of(opc, res);
    end
    exec_op = r;
  endfunction

  assign in_cur = {i_instr_valid, i_instr};
  assign o_instr_ready = ((s_reg.fsm == S_RUN) || (s_reg.fsm == S_EXT)) &&
                         !s_reg.rst_pend;
  assign o_rdata = s_reg.rdata;
  assign o_pc = s_reg.pc;
  assign o_flags = s_reg.fl;
  assign o_sw_reset = s_reg.rst_pend;

  always_comb begin
    s_next = s_reg;
    s_next.rdata = 16'h0000;
    // Register port read
    if (i_rd) begin
      s_next.rdata = port_read(s_reg, i_addr);
    end
    // Register port write
    if (i_wr) begin
      s_next = port_write(s_next, i_addr, i_wdata);
    end
    // Execution
    if (s_reg.rst_pend) begin
      s_next = '0; // [RQ9]
    end else begin
      case (s_reg.fsm)
        S_RUN: begin
          if (in_cur.valid) begin
            s_next = exec_op(s_next, in_cur.word, 1'b1);
            if (s_reg.rep_pend) begin
              s_next.rep_pend = 1'b0;
              if (s_reg.rep_cnt != 16'h0000) begin
                s_next.rep_instr = in_cur.word; // [RQ8]
                s_next.fsm = S_REP; // [RQ8]
              end
            end
          end
        end
        S_REP: begin
          s_next = exec_op(s_next, s_reg.rep_instr, 1'b0); // [RQ8]
          s_next.rep_cnt = s_reg.rep_cnt - 16'h0001;
          if (s_reg.rep_cnt == 16'h0001) begin
            s_next.fsm = S_RUN;
          end else begin
            s_next.fsm = S_REP;
          end
        end
        S_STALL: begin
          s_next.stall = s_reg.stall - 2'h1; // [RQ7] [RQ10]
          if (s_reg.stall == 2'h1) begin
            s_next.fsm = S_RUN;
          end
        end
        S_EXT: begin
          if (in_cur.valid) begin
            s_next.pc = s_reg.pc + 16'h0001; // [RQ2]
            s_next.fsm = S_RUN;
          end
        end
        default: s_next.fsm = S_RUN;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule

// ===== hdl/srx_pkg.sv
package srx_pkg;
`include "srx_consts.svh"

  typedef enum logic [1:0] {
    S_RUN = 2'b00,
    S_STALL = 2'b01,
    S_REP = 2'b10,
    S_EXT = 2'b11
  } srx_fsm_t;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic c;
  } srx_flags_t;

  typedef struct packed {
    logic valid;
    logic [`SRX_INSTR_W-1:0] word;
  } srx_instr_t;

  typedef struct packed {
    srx_fsm_t fsm;
    logic [15:0] pc;
    logic [15:0] rep_cnt;
    logic [`SRX_INSTR_W-1:0] rep_instr;
    logic rep_pend;
    logic rst_pend;
    logic [1:0] stall;
    logic [2:0] sp;
    logic fast_ret;
    srx_flags_t fl;
    logic [`SRX_NREGS-1:0][15:0] w;
    logic [`SRX_RAM_WORDS-1:0][15:0] ram;
    logic [`SRX_STK_DEPTH-1:0][15:0] stk;
    logic [15:0] rdata;
  } srx_state_t;

endpackage

// ===== testbench/shift_rotate_flow_exec_bench.sv
`timescale 1ns/10ps
`include "srx_consts.svh"
module shift_rotate_flow_exec_bench;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_instr_valid = 1'b0;
  logic [23:0] i_instr = 24'h000000;
  logic [7:0] i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic o_instr_ready;
  logic o_sw_reset;
  logic [15:0] o_rdata;
  logic [15:0] o_pc;
  logic [3:0] o_flags;
  logic [15:0] d;
  logic [15:0] p;
  logic [79:0] r;
  int fails = 0;
  int checked = 0;
  // Rows: opcode, low word, load addr, load value, flags in, result addr, result, flags out
  logic [79:0] tab [26] = '{80'hD7_0101_01_8001_0_02_0002_1, 80'hD7_0101_01_8001_1_02_0003_1,
    80'hD3_0101_01_8001_0_02_4000_1, 80'hD3_0101_01_8001_1_02_C000_9,
    80'hD5_0101_01_8001_5_02_0003_5, 80'hD1_0101_01_8001_0_02_C000_8,
    80'hD9_0101_01_0001_F_02_0002_0, 80'hFB_0101_01_0080_5_02_FF80_C,
    80'hEF_0001_01_1234_A_01_FFFF_A, 80'hDD_0904_01_0F01_5_02_F010_D,
    80'hDD_0910_01_0F01_5_02_0000_7, 80'hD6_0004_42_8001_0_00_0002_1,
    80'hD4_2004_42_8001_0_42_0003_0, 80'hD1_0123_42_0001_0_02_8000_8,
    80'hEE_2004_42_0000_F_42_FFFF_F, 80'hD2_0004_42_0001_0_00_0000_3,
    80'hD3_0143_44_0002_0_02_0001_0, 80'hD7_0153_43_4000_1_02_8001_8,
    80'hD9_0133_43_C000_0_02_8000_9, 80'hFB_0113_42_127F_0_02_007F_1,
    80'hD5_0963_01_0002_0_02_8001_8, 80'hEF_0023_42_0000_5_42_FFFF_5,
    80'hD8_0004_42_4001_0_00_8002_C, 80'hDC_0903_01_0003_0_02_00C0_0,
    80'hEE_0004_00_1234_3_00_FFFF_3, 80'hD0_2004_42_0002_2_42_0001_0};
  logic [7:0] tw [3] = '{`SRX_OP_TW0, `SRX_OP_TW1, `SRX_OP_TW2};
  always #12.5 i_clk = ~i_clk;
  srx_exec_unit u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .o_instr_ready(o_instr_ready), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pc(o_pc), .o_flags(o_flags),
    .o_sw_reset(o_sw_reset));
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  task automatic exec(input logic [23:0] w);
    logic tk;
    tk = 1'b0;
    @(posedge i_clk);
    i_instr_valid <= 1'b1;
    i_instr <= w;
    for (int n = 0; n < 20 && !tk; n++) begin
      @(negedge i_clk);
      tk = (o_instr_ready === 1'b1);
      @(posedge i_clk);
    end
    i_instr_valid <= 1'b0;
    #1;
    if (!tk) begin
      fails++;
      report_and_stop();
    end
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    i_nrst <= 1'b1;
    #1;
    chk("pc", o_pc, 16'h0000);
    chk("ready", {15'h0000, o_instr_ready}, 16'h0001);
    wr(8'h03, 16'h0004);
    foreach (tab[i]) begin
      r = tab[i];
      wr(r[55:48], r[47:32]);
      wr(`SRX_A_STATUS, {12'h000, r[31:28]});
      exec({r[79:72], r[71:56]});
      chk("flags", {12'h000, o_flags}, {12'h000, r[3:0]});
      rd(`SRX_A_STATUS, d);
      chk("status", d, {12'h000, r[3:0]});
      rd(r[27:20], d);
      chk("result", d, r[19:4]);
    end
    rd(8'h03, d);
    chk("pointer", d, 16'h0006);
    p = o_pc;
    exec({`SRX_OP_RELATIVE_CALL_OP, 16'h0010});
    chk("pc", o_pc, p + 16'h0011);
    exec({`SRX_OP_RETURN, 16'h0000});
    repeat (3) @(posedge i_clk);
    chk("pc", o_pc, p + 16'h0001);
    wr(8'h04, 16'h0100);
    exec({`SRX_OP_CALLW, 16'h0004});
    chk("pc", o_pc, 16'h0100);
    rd(`SRX_A_PC, d);
    chk("pc reg", d, 16'h0100);
    exec({`SRX_OP_LITERAL_RETURN_OP, 16'h1555});
    rd(8'h05, d);
    chk("literal", d, 16'h0155);
    wr(`SRX_A_CTRL, 16'h0001);
    rd(`SRX_A_CTRL, d);
    chk("fast return", d, 16'h0001);
    p = o_pc;
    exec({`SRX_OP_RELATIVE_CALL_OP, 16'h0000});
    exec({`SRX_OP_INTERRUPT_RETURN_OP, 16'h0000});
    repeat (2) @(posedge i_clk);
    chk("pc", o_pc, p + 16'h0001);
    wr(8'h02, 16'h0001);
    exec({`SRX_OP_REPL, 16'h0002});
    rd(`SRX_A_REPCNT, d);
    chk("repeat count", d, 16'h0002);
    exec({`SRX_OP_ROTATE_LEFT_PLAIN_W, 16'h0102});
    wr(8'h06, 16'h0000);
    exec({`SRX_OP_REPW, 16'h0006});
    exec({`SRX_OP_ROTATE_LEFT_PLAIN_W, 16'h0102});
    rd(8'h02, d);
    chk("repeat", d, 16'h0010);
    foreach (tw[i]) begin
      p = o_pc;
      exec({tw[i], 16'h0000});
      exec({`SRX_OP_ROTATE_LEFT_PLAIN_W, 16'h0102});
      chk("pc", o_pc, p + 16'h0002);
    end
    rd(8'h02, d);
    chk("skipped", d, 16'h0010);
    rd(8'h20, d);
    chk("unmapped", d, 16'h0000);
    exec({`SRX_OP_RESET, 16'h0000});
    chk("reset pulse", {15'h0000, o_sw_reset}, 16'h0001);
    rd(8'h02, d);
    chk("cleared", d, 16'h0000);
    chk("pc", o_pc, 16'h0000);
    report_and_stop();
  end
endmodule
bind srx_exec_unit srx_exec_asserts u_chk (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_instr_valid(i_instr_valid), .i_instr(i_instr), .o_instr_ready(o_instr_ready),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_pc(o_pc), .o_flags(o_flags), .o_sw_reset(o_sw_reset));

// ===== testbench/srx_exec_asserts.sv
`timescale 1ns/10ps
`include "srx_consts.svh"
module srx_exec_asserts (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Instruction stream
  input wire logic i_instr_valid,
  input wire logic [`SRX_INSTR_W-1:0] i_instr,
  input wire logic o_instr_ready,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  // Core status
  input wire logic [15:0] o_pc,
  input wire logic [3:0] o_flags,
  input wire logic o_sw_reset
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic tk;
  logic rep_q;
  logic [7:0] op;
  assign tk = i_instr_valid && o_instr_ready;
  assign op = i_instr[`SRX_F_OPC];
  // Remembers a repeat word so its follower is not taken as single-cycle
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) rep_q <= 1'b0;
    else if (tk) rep_q <= (op == `SRX_OP_REPL) || (op == `SRX_OP_REPW);
  end
  a_pc_step: assert property (tk && op[7:4] == 4'hD |=> o_pc == $past(o_pc) + 16'h0001)
    else $error("pc did not step by one");
  a_one_cycle: assert property (tk && !rep_q && op[7:4] == 4'hD |=> o_instr_ready)
    else $error("shift or rotate stalled");
  a_call_stall: assert property (tk && (op == `SRX_OP_RELATIVE_CALL_OP || op == `SRX_OP_CALLW)
    |=> (!o_instr_ready && $stable(o_flags)) ##1 o_instr_ready)
    else $error("call timing or flags wrong");
  a_ret_stall: assert property (tk && (op == `SRX_OP_RETURN || op == `SRX_OP_INTERRUPT_RETURN_OP ||
    op == `SRX_OP_LITERAL_RETURN_OP) |=> (!o_instr_ready && $stable(o_flags)) ##[1:2] o_instr_ready)
    else $error("return timing or flags wrong");
  a_reset_pulse: assert property (tk && op == `SRX_OP_RESET |=>
    (o_sw_reset && !o_instr_ready && $stable(o_flags)) ##1 (!o_sw_reset && o_pc == 16'h0000))
    else $error("software reset sequence wrong");
  a_plain_rot: assert property (tk && op inside {8'hD0, 8'hD1, 8'hD4, 8'hD5}
    |=> (o_flags & 4'h5) == ($past(o_flags) & 4'h5))
    else $error("plain rotate touched carry or overflow");
  a_fill_flags: assert property (tk && (op == `SRX_OP_FILL_F || op == `SRX_OP_FILL_W)
    |=> $stable(o_flags))
    else $error("fill changed flags");
  a_multi_shift: assert property (tk && (op == `SRX_OP_SLM_W || op == `SRX_OP_SLM_L)
    |=> (o_flags & 4'h5) == ($past(o_flags) & 4'h5))
    else $error("multi shift touched carry or overflow");
  a_repeat_one: assert property (tk && op == `SRX_OP_REPL |=> o_instr_ready)
    else $error("repeat word stalled");
endmodule
